// ===== hw/ssp_consts.vh
// Constants shared by the serial port design files
`ifndef SSP_CONSTS_VH
`define SSP_CONSTS_VH
`define SSP_SYS_CLK_NS 40
`define SSP_SCLK_HALF_NS 160
`define SSP_LAST_EDGE 4'hF
`define SSP_DATA_RESET 8'h00
`define SSP_ST_IDLE 2'h1
`define SSP_ST_SHIFT 2'h2
`endif

// ===== hw/ssp_fifo2.v
// Two-entry receive buffer with valid and ready on both sides
`timescale 1ns/100ps
`include "ssp_consts.vh"
module ssp_fifo2 (
  input wire sys_clk,
  input wire rstInt,
  input wire inValid,
  output wire inReady,
  input wire [7:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [7:0] outData
);
  reg [7:0] mem_q [0:1]; // Storage words
  reg wrPtr_q; // Next slot to fill
  reg rdPtr_q; // Oldest slot
  reg [1:0] count_q; // Words held
  wire push;
  wire pop;
  // Honest full and empty from the word count
  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  assign push = inValid & inReady;
  assign pop = outValid & outReady;
  // Pointer and count update; push and pop may share a cycle
  always @(posedge sys_clk) begin
    if (rstInt) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
      mem_q[0] <= `SSP_DATA_RESET;
      mem_q[1] <= `SSP_DATA_RESET;
    end else begin
      if (push) begin
        mem_q[wrPtr_q] <= inData;
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      if (push & ~pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop & ~push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule

// ===== hw/ssp_serial_port.v
// Serial peripheral port, master or slave, with receive buffering
`timescale 1ns/100ps
`include "ssp_consts.vh"
module ssp_serial_port (
  input wire sys_clk,
  input wire rstn,
  input wire masterMode,
  input wire fourPin,
  input wire selectPinMode,
  input wire clockPhaseBit,
  input wire clockPolarityBit,
  input wire softwareResetBit,
  input wire [7:0] txData,
  input wire txValid,
  output wire txReady,
  output wire transmitReadyFlag,
  output wire [7:0] rxData,
  output wire rxValid,
  input wire rxReady,
  output wire receiveReadyFlag,
  output wire busyIndicator,
  output wire clockRequest,
  input wire sclkIn,
  output wire sclkOut,
  output wire sclkOe,
  input wire slaveSelectPinIn,
  output wire slaveSelectPinOut,
  output wire slaveSelectPinOe,
  input wire simoIn,
  output wire simoOut,
  output wire simoOe,
  input wire somiIn,
  output wire somiOut,
  output wire somiOe
);
  // Half period of the master clock in system cycles, rounded up
  localparam [31:0] HALF_FULL =
    (`SSP_SCLK_HALF_NS + `SSP_SYS_CLK_NS - 1) / `SSP_SYS_CLK_NS;
  // Counter is three bits wide; the quotient is cut on purpose
  localparam [2:0] HALF_CYCLES = HALF_FULL[2:0];

  // Sample edges are even for phase 0, odd for phase 1
  function isSample;
    input phase;
    input oddEdge;
    begin
      isSample = phase ? oddEdge : ~oddEdge;
    end
  endfunction

  wire rstInt; // Combined hard and software reset
  wire [3:0] pinsRaw; // Asynchronous pin inputs
  reg [3:0] meta_q; // First synchroniser stage
  reg [3:0] sync_q; // Second synchroniser stage
  wire sclkS;
  wire steActive; // Select pin, active low
  wire simoS;
  wire somiS;
  reg sclkPrev_q; // Previous synced clock, for edge finding
  reg [1:0] state_q; // Master sequencer, one-hot
  reg [2:0] halfCnt_q; // Master half-period counter
  reg [3:0] edgeCnt_q; // Clock edges seen in this character
  reg [7:0] txBuf_q; // Transmit buffer
  reg txFull_q; // Transmit buffer holds a character
  reg [7:0] txSh_q; // Transmit shifter
  reg [7:0] rxSh_q; // Receive shifter
  reg outBit_q; // Data bit on the output pin
  reg sclk_q; // Master clock level
  reg slvLoaded_q; // Slave shifter holds the next character
  wire conflictMode;
  wire slvEnable;
  wire masterEv;
  wire ev; // One clock edge of the character, either mode
  wire sampleEv;
  wire lastEv;
  wire abort;
  wire start;
  wire slvLoad;
  wire inBit;
  wire [7:0] rxWord;
  wire rxInReady;
  wire txWrite;

  assign rstInt = ~rstn | softwareResetBit;
  assign pinsRaw = {somiIn, simoIn, slaveSelectPinIn, sclkIn};

  // Two flip-flops per pin before any logic looks at it
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gSync
      always @(posedge sys_clk) begin
        if (~rstn) begin
          // Select pin starts inactive (high), so no false select after reset
          meta_q[g] <= (g == 1) ? 1'b1 : 1'b0;
          sync_q[g] <= (g == 1) ? 1'b1 : 1'b0;
        end else begin
          meta_q[g] <= pinsRaw[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign sclkS = sync_q[0];
  assign steActive = ~sync_q[1];
  assign simoS = sync_q[2];
  assign somiS = sync_q[3];

  // Mode decode
  assign conflictMode = masterMode & fourPin & ~selectPinMode;
  assign slvEnable = ~masterMode & (~fourPin | steActive);
  assign masterEv = (state_q == `SSP_ST_SHIFT) & (halfCnt_q == HALF_CYCLES - 3'h1);
  // Previous level is tracked from reset, so an idle clock gives no false edge except once after a hard reset with the clock idling high
  assign ev = masterMode ? masterEv : (slvEnable & (sclkS ^ sclkPrev_q));
  assign sampleEv = ev & isSample(clockPhaseBit, edgeCnt_q[0]);
  assign lastEv = ev & (edgeCnt_q == `SSP_LAST_EDGE);
  assign abort = conflictMode & ~steActive & (state_q == `SSP_ST_SHIFT);
  // Master waits for room in the receive buffer, so nothing is dropped
  assign start = masterMode & (state_q == `SSP_ST_IDLE) & txFull_q & rxInReady &
    (~conflictMode | steActive);
  // Load only while selected; a deselected load would free the buffer and lose the word
  assign slvLoad = slvEnable & ~slvLoaded_q & txFull_q & (edgeCnt_q == 4'h0) & ~ev;
  assign inBit = masterMode ? somiS : simoS;
  // Phase 1 takes its last sample on the final edge itself
  assign rxWord = clockPhaseBit ? {rxSh_q[6:0], inBit} : rxSh_q;
  assign txWrite = txValid & ~txFull_q;

  // Handshakes and flags
  assign txReady = ~txFull_q;
  assign transmitReadyFlag = ~txFull_q;
  assign receiveReadyFlag = rxValid;
  assign busyIndicator = masterMode ? (state_q == `SSP_ST_SHIFT) : (edgeCnt_q != 4'h0);
  assign clockRequest = busyIndicator;

  // Pin drive
  assign sclkOut = sclk_q;
  assign sclkOe = masterMode;
  assign slaveSelectPinOut = ~(state_q == `SSP_ST_SHIFT);
  assign slaveSelectPinOe = masterMode & fourPin & selectPinMode;
  assign simoOut = outBit_q;
  assign simoOe = masterMode;
  assign somiOut = outBit_q;
  assign somiOe = slvEnable;

  // Edge history of the synced clock
  always @(posedge sys_clk) begin
    if (rstInt) begin
      // Follow the synced pin in reset; hard reset clears it low, so a clock idling high shows one false edge after release
      sclkPrev_q <= sclkS;
    end else begin
      sclkPrev_q <= sclkS;
    end
  end

  // Transmit buffer; write only when empty, so set and clear never meet
  always @(posedge sys_clk) begin
    if (rstInt) begin
      txBuf_q <= `SSP_DATA_RESET;
      txFull_q <= 1'b0;
    end else if (txWrite) begin
      txBuf_q <= txData;
      txFull_q <= 1'b1;
    end else if (start | slvLoad) begin
      txFull_q <= 1'b0;
    end
  end

  // Master sequencer and clock generator
  always @(posedge sys_clk) begin
    if (rstInt) begin
      state_q <= `SSP_ST_IDLE;
      halfCnt_q <= 3'h0;
      sclk_q <= 1'b0;
    end else begin
      case (state_q)
        `SSP_ST_IDLE: begin
          sclk_q <= clockPolarityBit;
          halfCnt_q <= 3'h0;
          if (start) begin
            state_q <= `SSP_ST_SHIFT;
          end
        end
        `SSP_ST_SHIFT: begin
          if (abort | ~masterMode) begin
            // Character is lost; software must write it again
            state_q <= `SSP_ST_IDLE;
          end else if (masterEv) begin
            halfCnt_q <= 3'h0;
            sclk_q <= ~sclk_q;
            if (lastEv) begin
              state_q <= `SSP_ST_IDLE;
            end
          end else begin
            halfCnt_q <= halfCnt_q + 3'h1;
          end
        end
        default: begin
          state_q <= `SSP_ST_IDLE;
        end
      endcase
    end
  end

  // Shared shift datapath for master and slave
  always @(posedge sys_clk) begin
    if (rstInt) begin
      edgeCnt_q <= 4'h0;
      txSh_q <= `SSP_DATA_RESET;
      rxSh_q <= `SSP_DATA_RESET;
      outBit_q <= 1'b0;
      slvLoaded_q <= 1'b0;
    end else if (abort | (~masterMode & fourPin & ~steActive)) begin
      // Deselect or abort restarts the character count
      edgeCnt_q <= 4'h0;
    end else if (start | slvLoad) begin
      txSh_q <= txBuf_q;
      outBit_q <= txBuf_q[7];
      slvLoaded_q <= ~masterMode;
      edgeCnt_q <= 4'h0;
    end else if (ev) begin
      edgeCnt_q <= edgeCnt_q + 4'h1;
      if (sampleEv) begin
        rxSh_q <= {rxSh_q[6:0], inBit};
      end else if (clockPhaseBit) begin
        outBit_q <= txSh_q[7];
        txSh_q <= {txSh_q[6:0], 1'b0};
      end else begin
        outBit_q <= txSh_q[6];
        txSh_q <= {txSh_q[6:0], 1'b0};
      end
      if (lastEv) begin
        // Empty shifter sends zeros if software left the buffer empty
        slvLoaded_q <= 1'b0;
        txSh_q <= `SSP_DATA_RESET;
      end
    end
  end

  // Receive buffer; a slave overrun with both entries full is dropped
  ssp_fifo2 uRxFifo (
    .sys_clk(sys_clk),
    .rstInt(rstInt),
    .inValid(lastEv),
    .inReady(rxInReady),
    .inData(rxWord),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );
endmodule

// ===== verif/ssp_serial_port_asserts.sv
// Concurrent checks on the serial port flags and pins
`timescale 1ns/100ps
module ssp_serial_port_asserts (
  input wire sys_clk,
  input wire rstn,
  input wire masterMode,
  input wire fourPin,
  input wire selectPinMode,
  input wire clockPolarityBit,
  input wire softwareResetBit,
  input wire txValid,
  input wire txReady,
  input wire transmitReadyFlag,
  input wire [7:0] rxData,
  input wire rxValid,
  input wire rxReady,
  input wire receiveReadyFlag,
  input wire busyIndicator,
  input wire clockRequest,
  input wire sclkOut,
  input wire slaveSelectPinIn,
  input wire slaveSelectPinOe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Select held inactive long enough to pass the synchronisers
  sequence selGone;
    slaveSelectPinIn [*3];
  endsequence
  a_clock_request:
    assert property (clockRequest == busyIndicator) else $error("clock request not busy");
  a_idle_level:
    assert property (masterMode && !busyIndicator && !$past(busyIndicator) && $past(rstn, 2)
      && !$past(softwareResetBit, 2) && !softwareResetBit |-> sclkOut == clockPolarityBit)
      else $error("clock idle level wrong");
  a_flag_mirror:
    assert property (transmitReadyFlag == txReady && receiveReadyFlag == rxValid)
      else $error("ready flags differ");
  a_write_taken:
    assert property (txValid && txReady && !softwareResetBit |=> !txReady)
      else $error("write not taken");
  a_swrst_hold:
    assert property (softwareResetBit [*2] |-> txReady && !rxValid && !busyIndicator)
      else $error("port not held in reset");
  a_select_drive:
    assert property (slaveSelectPinOe == (masterMode && fourPin && selectPinMode))
      else $error("select enable wrong");
  a_conflict_abort:
    assert property (masterMode && fourPin && !selectPinMode && busyIndicator ##0 selGone
      |=> ##[0:2] !busyIndicator) else $error("transfer not aborted");
  a_rx_hold:
    assert property (rxValid && !rxReady && !softwareResetBit |=> rxValid && $stable(rxData))
      else $error("receive word lost");
endmodule
bind ssp_serial_port ssp_serial_port_asserts ssp_serial_port_asserts_i (.*);

// ===== verif/ssp_spi_peer.sv
// Far-side device: slave to a master port, master to a slave port
`timescale 1ns/100ps
module ssp_spi_peer (
  input wire cpol,
  input wire cpha,
  input wire sclk,
  input wire sel,
  input wire mosi,
  input wire miso,
  output logic peerMiso = 1'b0,
  output logic mSclk = 1'b0,
  output logic mSel = 1'b1,
  output logic mMosi = 1'b0,
  output logic [7:0] gotMosi,
  output logic [7:0] gotMiso
);
  logic [7:0] slvTx = 8'hC3; // Reply, steps by 8'h11 each frame
  logic [2:0] idx; // Reply bit pointer
  wire selLate; // Select seen just after a clock edge of the same step
  assign #5 selLate = sel;
  // Clock stands at idle between frames
  always @* if (mSel) mSclk = cpol;
  // Select edges: preload first bit in phase 0, or let the line go
  always @(sel) begin
    if (!sel) begin
      idx = 3'h7;
      if (!cpha) peerMiso = slvTx[7];
    end else begin
      peerMiso = ~peerMiso; // Released line shows no stale bit
      slvTx = slvTx + 8'h11;
    end
  end
  // Sample on one edge, shift on the other
  always @(sclk) begin
    if (!selLate && (sclk ^ cpol ^ cpha)) begin
      gotMosi = {gotMosi[6:0], mosi};
      gotMiso = {gotMiso[6:0], miso};
    end else if (!selLate) begin
      if (!cpha) idx = idx - 3'h1;
      peerMiso = slvTx[idx];
      if (cpha) idx = idx - 3'h1;
    end
  end
  // One master frame, 16 edges 160 ns apart
  task automatic mxfer(input logic [7:0] b);
    int i;
    mSel = 1'b0;
    mMosi = b[7];
    #320;
    for (i = 0; i < 16; i++) begin
      mSclk = ~mSclk;
      if (i[0] != cpha && i < 15) mMosi = b[7 - (i + 1 - cpha) / 2];
      #160;
    end
    #160;
    mSel = 1'b1;
    mMosi = ~mMosi;
  endtask
endmodule

// ===== verif/tb_ssp_serial_port.sv
// Self-checking bench: both roles, all clock modes, buffer and abort
`timescale 1ns/100ps
module tb_ssp_serial_port;
  logic sys_clk = 1'b0, rstn = 1'b0, masterMode = 1'b1, fourPin = 1'b1, selectPinMode = 1'b1;
  logic clockPhaseBit = 1'b0, clockPolarityBit = 1'b0, softwareResetBit = 1'b1;
  logic txValid = 1'b0, rxReady = 1'b0;
  logic [7:0] txData = 8'h00, rxData, s, b;
  logic txReady, transmitReadyFlag, rxValid, receiveReadyFlag, busyIndicator, clockRequest;
  logic sclkOut, sclkOe, slaveSelectPinOut, slaveSelectPinOe, simoOut, simoOe, somiOut, somiOe;
  wire sclkIn, slaveSelectPinIn, simoIn, somiIn, pMiso, pSclk, pSel, pMosi;
  wire [7:0] gotMosi, gotMiso;
  wire [2:0] flags = {txReady, busyIndicator, rxValid}; // Wait targets
  int num_errors = 0, n_tests = 0, cyc = 0, m;
  // Pin levels from whichever party drives
  assign sclkIn = sclkOe ? sclkOut : pSclk;
  assign slaveSelectPinIn = slaveSelectPinOe ? slaveSelectPinOut : pSel;
  assign simoIn = simoOe ? simoOut : pMosi;
  assign somiIn = somiOe ? somiOut : pMiso;
  ssp_serial_port ssp_serial_port_i (.*);
  ssp_spi_peer ssp_spi_peer_i (.cpol(clockPolarityBit), .cpha(clockPhaseBit), .sclk(sclkIn),
    .sel(slaveSelectPinIn), .mosi(simoIn), .miso(somiIn), .peerMiso(pMiso), .mSclk(pSclk),
    .mSel(pSel), .mMosi(pMosi), .gotMosi(gotMosi), .gotMiso(gotMiso));
  always #20 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Bounded wait at negedge: 0 receive, 1 busy, 2 transmit ready
  task automatic waitHigh(input int w);
    int k = 0;
    do @(negedge sys_clk); while (flags[w] !== 1'b1 && ++k < 3000);
  endtask
  task send(input logic [7:0] v);
    waitHigh(2);
    @(posedge sys_clk);
    txData <= v;
    txValid <= 1'b1;
    tick(1);
    txValid <= 1'b0;
  endtask
  task pop(input logic [7:0] e);
    waitHigh(0);
    check("rxData", rxData, e);
    tick(1);
    rxReady <= 1'b1;
    tick(1);
    rxReady <= 1'b0;
  endtask
  task end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    tick(5);
    rstn <= 1'b1;
    // Every phase and polarity, slave then master
    for (m = 0; m < 8; m++) begin
      softwareResetBit <= 1'b1;
      {masterMode, clockPolarityBit, clockPhaseBit} <= m[2:0];
      tick(3);
      softwareResetBit <= 1'b0;
      tick(3);
      s = ssp_spi_peer_i.slvTx;
      b = 8'h5A ^ m[7:0];
      send(b);
      if (!m[2]) ssp_spi_peer_i.mxfer(~b);
      pop(m[2] ? s : ~b);
      check("wire", m[2] ? gotMosi : gotMiso, b);
      tick(8);
      check("busy", busyIndicator, 1'b0);
    end
    // Receive buffer fills, refuses, drains; reset mid-frame
    s = ssp_spi_peer_i.slvTx;
    for (m = 0; m < 3; m++) send(8'h30 + m[7:0]);
    tick(100);
    check("txFull", txReady, 1'b0);
    pop(s);
    pop(s + 8'h11);
    waitHigh(1);
    check("empty", rxValid, 1'b0);
    tick(20);
    softwareResetBit <= 1'b1;
    tick(2);
    check("reset", {busyIndicator, rxValid, txReady}, 3'h1);
    // Conflict mode: abort, then rewrite once select returns
    selectPinMode <= 1'b0;
    ssp_spi_peer_i.mSel <= 1'b0;
    tick(3);
    softwareResetBit <= 1'b0;
    send(8'h96);
    waitHigh(1);
    tick(20);
    ssp_spi_peer_i.mSel <= 1'b1;
    tick(6);
    check("abort", {busyIndicator, rxValid}, 2'h0);
    ssp_spi_peer_i.mSel <= 1'b0;
    s = ssp_spi_peer_i.slvTx;
    send(8'h96);
    pop(s);
    check("resend", gotMosi, 8'h96);
    end_sim();
  end
endmodule
